// ==== rtl/umf_modem_pins.sv ====
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module umf_modem_pins
   import umf_pkg::*;
#(
   parameter int NCH = UMF_NCH,
   parameter int FW = UMF_FILL_W
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [UMF_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // uart core side
   input wire logic [NCH*FW-1:0] rx_fill_in,
   input wire logic [NCH-1:0] tx_empty_in,
   input wire logic [NCH-1:0] tx_busy_in,
   input wire logic [NCH-1:0] tx_data_req_in,
   input wire logic [NCH-1:0] tx_flow_req_in,
   input wire logic [NCH-1:0] tx_bclk_in,
   input wire logic [NCH-1:0] tx_nclk_in,
   input wire logic [NCH-1:0] rx_bclk_in,
   output logic [NCH-1:0] tx_data_start_out,
   output logic [NCH-1:0] tx_flow_start_out,
   output logic [NCH-1:0] tx_tick_out,
   output logic [NCH-1:0] rx_tick_out,
   output logic [NCH-1:0] fifo_deep_out,
   // modem pins
   input wire logic [NCH-1:0] cts_n_in,
   input wire logic [NCH-1:0] dsr_n_in,
   input wire logic [NCH-1:0] ri_n_in,
   input wire logic queue_depth_select_pin_in,
   output logic [NCH-1:0] rts_n_out,
   output logic [NCH-1:0] dtr_n_out,
   output logic [NCH-1:0] ring_out
);
   logic [1:0] mcr [NCH];
   logic [3:0] flow [NCH];
   logic [1:0] dtr_mode [NCH];
   logic [6:0] clock_select_register [NCH];
   logic [FW-1:0] rts_thr [NCH];
   logic [FW-1:0] dtr_thr [NCH];
   logic [NCH-1:0] tx_held;
   logic setup, wr_en, hit, ch_ok;
   logic [4:0] off;
   logic [31:0] next_rdata;
   int unsigned ch;

   // address decode; unmapped words answer with an error
   assign setup = psel_in & ~penable_in;
   assign off = paddr_in[4:0];
   assign ch = 32'(paddr_in[UMF_ADDR_W-1:UMF_CH_BIT]);
   assign ch_ok = ch < NCH;
   assign hit = ch_ok &&
      (off == UMF_OFF_MCR || off == UMF_OFF_FLOW || off == UMF_OFF_ACR ||
       off == UMF_OFF_CKS || off == UMF_OFF_THR || off == UMF_OFF_STAT);
   // writes land only at the completing edge of the access phase
   assign wr_en = psel_in & penable_in & pready_out & pwrite_in &
                  ~pslverr_out;

   // read mux, sampled in the setup cycle
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (ch_ok) begin
         unique case (off)
            UMF_OFF_MCR: next_rdata[1:0] = mcr[ch];
            UMF_OFF_FLOW: next_rdata[3:0] = flow[ch];
            UMF_OFF_ACR: next_rdata[4:3] = dtr_mode[ch];
            UMF_OFF_CKS: next_rdata[6:0] = clock_select_register[ch];
            UMF_OFF_THR: next_rdata[2*FW-1:0] = {dtr_thr[ch], rts_thr[ch]};
            UMF_OFF_STAT: begin
               next_rdata[0] = ~cts_n_in[ch];
               next_rdata[1] = ~dsr_n_in[ch];
               next_rdata[2] = ring_out[ch];
               next_rdata[3] = tx_held[ch];
               next_rdata[4] = rts_n_out[ch];
               next_rdata[5] = dtr_n_out[ch];
               next_rdata[6] = fifo_deep_out[ch];
               next_rdata[7] = queue_depth_select_pin_in;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // one wait-free access phase: pready rises the cycle after setup
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= setup;
         pslverr_out <= setup & ~hit;
         if (setup)
            prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic sel;
         assign sel = wr_en && (ch == g);

         // software-owned control registers of this channel
         always_ff @(posedge clk_sys_in) begin
            if (srst_in) begin
               mcr[g] <= UMF_MCR_RST;
               flow[g] <= UMF_FLOW_RST;
               dtr_mode[g] <= UMF_ACR_RST;
               clock_select_register[g] <= UMF_CKS_RST;
               rts_thr[g] <= FW'(UMF_THR_RST);
               dtr_thr[g] <= FW'(UMF_THR_RST);
            end else if (sel) begin
               unique case (off)
                  UMF_OFF_MCR: mcr[g] <= pwdata_in[1:0];
                  UMF_OFF_FLOW: flow[g] <= pwdata_in[3:0];
                  UMF_OFF_ACR: dtr_mode[g] <= pwdata_in[4:3];
                  UMF_OFF_CKS: clock_select_register[g] <= pwdata_in[6:0];
                  UMF_OFF_THR: begin
                     rts_thr[g] <= pwdata_in[FW-1:0];
                     dtr_thr[g] <= pwdata_in[2*FW-1:FW];
                  end
                  default: ; // status is read-only
               endcase
            end
         end

         umf_chan #(.FW(FW)) u_chan (
            .clk_sys_in(clk_sys_in),
            .srst_in(srst_in),
            .rx_fill_in(rx_fill_in[g*FW +: FW]),
            .rts_thr_in(rts_thr[g]),
            .dtr_thr_in(dtr_thr[g]),
            .mcr_in(mcr[g]),
            .flow_in(flow[g]),
            .dtr_mode_in(dtr_mode[g]),
            .cks_in(clock_select_register[g]),
            .tx_empty_in(tx_empty_in[g]),
            .tx_busy_in(tx_busy_in[g]),
            .tx_data_req_in(tx_data_req_in[g]),
            .tx_flow_req_in(tx_flow_req_in[g]),
            .tx_bclk_in(tx_bclk_in[g]),
            .tx_nclk_in(tx_nclk_in[g]),
            .rx_bclk_in(rx_bclk_in[g]),
            .cts_n_in(cts_n_in[g]),
            .dsr_n_in(dsr_n_in[g]),
            .ri_n_in(ri_n_in[g]),
            .queue_depth_select_pin_in(queue_depth_select_pin_in),
            .rts_n_out(rts_n_out[g]),
            .dtr_n_out(dtr_n_out[g]),
            .tx_data_start_out(tx_data_start_out[g]),
            .tx_flow_start_out(tx_flow_start_out[g]),
            .tx_tick_out(tx_tick_out[g]),
            .rx_tick_out(rx_tick_out[g]),
            .ring_out(ring_out[g]),
            .tx_held_out(tx_held[g]),
            .fifo_deep_out(fifo_deep_out[g])
         );

         // helpers for the checks below
         logic cko_off, auto_dtr, manual;
         assign cko_off = clock_select_register[g][UMF_CKS_DTR_LO +: 2] == UMF_CKO_OFF;
         assign auto_dtr = cko_off && dtr_mode[g] == UMF_DTR_AUTO;
         assign manual = cko_off && dtr_mode[g] == UMF_DTR_MANUAL;

         // held off by cts for two sampled cycles in a row
         sequence s_cts_off;
            (flow[g][UMF_FLOW_CTS] && cts_n_in[g])[*2];
         endsequence
         sequence s_dsr_off;
            (flow[g][UMF_FLOW_DSR] && dsr_n_in[g])[*2];
         endsequence
         sequence s_flow_wait;
            tx_flow_req_in[g] && !tx_busy_in[g] &&
            !tx_flow_start_out[g] && !tx_data_start_out[g];
         endsequence

         a_dtr_auto_level: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            auto_dtr && $stable(dtr_mode[g]) |=>
               dtr_n_out[g] == !($past(rx_fill_in[g*FW +: FW]) >=
                                 $past(dtr_thr[g])))
            else $error("terminal-ready ignores fill threshold");

         a_rts_auto_level: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            flow[g][UMF_FLOW_RTS] |=>
               rts_n_out[g] == ($past(rx_fill_in[g*FW +: FW]) >=
                                $past(rts_thr[g])))
            else $error("request-to-send ignores fill threshold");

         a_dtr_dir_485: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            cko_off && dtr_mode[g] == UMF_DTR_485_HI |=>
               dtr_n_out[g] == !$past(tx_empty_in[g]))
            else $error("direction enable does not track tx empty");

         // low-active direction enable is the raw empty level
         a_dtr_dir_low: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            cko_off && dtr_mode[g] == UMF_DTR_485_LO |=>
               dtr_n_out[g] == $past(tx_empty_in[g]))
            else $error("low direction enable does not track tx empty");

         // a grant is a single pulse; the core needs a cycle to go busy
         a_grant_gap: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            tx_data_start_out[g] || tx_flow_start_out[g] |=>
               !tx_data_start_out[g] && !tx_flow_start_out[g])
            else $error("start grants back to back");

         a_dtr_clk_out: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            clock_select_register[g][UMF_CKS_DTR_LO +: 2] == UMF_CKO_1X &&
            !clock_select_register[g][UMF_CKS_TX_EXT] |=> dtr_n_out[g] == $past(tx_bclk_in[g]))
            else $error("transmit clock missing on terminal-ready");

         a_cts_no_start: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            s_cts_off |-> !tx_data_start_out[g])
            else $error("data started while clear-to-send is off");

         a_dsr_no_start: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            s_dsr_off |-> !tx_data_start_out[g])
            else $error("data started while data-set-ready is off");

         a_flow_char_go: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            s_flow_wait |=> tx_flow_start_out[g])
            else $error("flow character not granted");

         a_rx_ext_tick: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            clock_select_register[g][1:0] == UMF_RX_EXT && $stable(clock_select_register[g]) &&
            $rose(dsr_n_in[g]) |=> rx_tick_out[g])
            else $error("receive clock edge lost");

         a_tx_ext_tick: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            clock_select_register[g][UMF_CKS_TX_EXT] && $stable(clock_select_register[g]) &&
            $rose(ri_n_in[g]) |=> tx_tick_out[g] ##1 !tx_tick_out[g])
            else $error("transmit clock edge wrong");

         a_ring_low: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            !clock_select_register[g][UMF_CKS_TX_EXT] |=> ring_out[g] == !$past(ri_n_in[g]))
            else $error("ring level wrong");

         a_depth_sel: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            1'b1 |=> fifo_deep_out[g] == ($past(queue_depth_select_pin_in) ||
                                         $past(flow[g][UMF_FLOW_DEEP])))
            else $error("queue depth select wrong");

         a_modem_manual: assert property (
            @(posedge clk_sys_in) disable iff (srst_in)
            manual && !flow[g][UMF_FLOW_RTS] |=>
               dtr_n_out[g] == !$past(mcr[g][UMF_MCR_DTR]) &&
               rts_n_out[g] == !$past(mcr[g][UMF_MCR_RTS]))
            else $error("modem pins do not follow software bits");
      end
   endgenerate

   // bus answer: exactly one access-phase cycle after setup
   a_apb_one_wait: assert property (
      @(posedge clk_sys_in) disable iff (srst_in)
      setup |=> pready_out ##1 !pready_out)
      else $error("apb answer timing wrong");
endmodule // umf_modem_pins
`default_nettype wire

// ==== rtl/umf_pkg.sv ====
package umf_pkg;
   // channel count and register window
   localparam int UMF_NCH = 2;
   localparam int UMF_FILL_W = 8;
   localparam int UMF_ADDR_W = 12;
   localparam logic [4:0] UMF_OFF_MCR = 5'h00;
   localparam logic [4:0] UMF_OFF_FLOW = 5'h04;
   localparam logic [4:0] UMF_OFF_ACR = 5'h08;
   localparam logic [4:0] UMF_OFF_CKS = 5'h0C;
   localparam logic [4:0] UMF_OFF_THR = 5'h10;
   localparam logic [4:0] UMF_OFF_STAT = 5'h14;
   localparam int UMF_CH_BIT = 5;
   // modem control fields
   localparam int UMF_MCR_DTR = 0;
   localparam int UMF_MCR_RTS = 1;
   // flow control fields
   localparam int UMF_FLOW_RTS = 0;
   localparam int UMF_FLOW_CTS = 1;
   localparam int UMF_FLOW_DSR = 2;
   localparam int UMF_FLOW_DEEP = 3;
   // additional control: terminal-ready mode in [4:3]
   localparam int UMF_ACR_DTR_LO = 3;
   localparam logic [1:0] UMF_DTR_MANUAL = 2'h0;
   localparam logic [1:0] UMF_DTR_AUTO = 2'h1;
   localparam logic [1:0] UMF_DTR_485_LO = 2'h2;
   localparam logic [1:0] UMF_DTR_485_HI = 2'h3;
   // clock select fields
   localparam int UMF_CKS_RX_LO = 0;
   localparam logic [1:0] UMF_RX_INT = 2'h0;
   localparam logic [1:0] UMF_RX_EXT = 2'h1;
   localparam int UMF_CKS_DTR_LO = 4;
   localparam logic [1:0] UMF_CKO_OFF = 2'h0;
   localparam logic [1:0] UMF_CKO_1X = 2'h1;
   localparam logic [1:0] UMF_CKO_NX = 2'h2;
   localparam int UMF_CKS_TX_EXT = 6;
   // reset values
   localparam logic [1:0] UMF_MCR_RST = 2'h0;
   localparam logic [3:0] UMF_FLOW_RST = 4'h0;
   localparam logic [1:0] UMF_ACR_RST = 2'h0;
   localparam logic [6:0] UMF_CKS_RST = 7'h00;
   localparam logic [7:0] UMF_THR_RST = 8'h40;
   // queue depths
   localparam int UMF_DEPTH_SHALLOW = 16;
   localparam int UMF_DEPTH_DEEP = 128;
endpackage

// ==== rtl/umf_chan.sv ====
`timescale 1ns/100ps
`default_nettype none
module umf_chan
   import umf_pkg::*;
#(
   parameter int FW = UMF_FILL_W
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic [FW-1:0] rx_fill_in,
   input wire logic [FW-1:0] rts_thr_in,
   input wire logic [FW-1:0] dtr_thr_in,
   input wire logic [1:0] mcr_in,
   input wire logic [3:0] flow_in,
   input wire logic [1:0] dtr_mode_in,
   input wire logic [6:0] cks_in,
   input wire logic tx_empty_in,
   input wire logic tx_busy_in,
   input wire logic tx_data_req_in,
   input wire logic tx_flow_req_in,
   input wire logic tx_bclk_in,
   input wire logic tx_nclk_in,
   input wire logic rx_bclk_in,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic ri_n_in,
   input wire logic queue_depth_select_pin_in,
   output logic rts_n_out,
   output logic dtr_n_out,
   output logic tx_data_start_out,
   output logic tx_flow_start_out,
   output logic tx_tick_out,
   output logic rx_tick_out,
   output logic ring_out,
   output logic tx_held_out,
   output logic fifo_deep_out
);
   logic tx_src, rx_src, tx_src_q, rx_src_q, hold;
   logic [1:0] cko, rx_sel;

   // clock sources: ring pin may replace the baud clock
   assign cko = cks_in[UMF_CKS_DTR_LO +: 2];
   assign rx_sel = cks_in[UMF_CKS_RX_LO +: 2];
   assign tx_src = cks_in[UMF_CKS_TX_EXT] ? ri_n_in : tx_bclk_in;
   assign rx_src = (rx_sel == UMF_RX_EXT) ? dsr_n_in :
                   (rx_sel == UMF_RX_INT) ? rx_bclk_in : tx_src;
   assign hold = (flow_in[UMF_FLOW_CTS] & cts_n_in) |
                 (flow_in[UMF_FLOW_DSR] & dsr_n_in);

   // modem outputs, highest priority first
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rts_n_out <= 1'b1;
         dtr_n_out <= 1'b1;
      end else begin
         if (flow_in[UMF_FLOW_RTS])
            rts_n_out <= (rx_fill_in >= rts_thr_in);
         else
            rts_n_out <= ~mcr_in[UMF_MCR_RTS];
         if (cko == UMF_CKO_1X)
            dtr_n_out <= tx_src;
         else if (cko == UMF_CKO_NX)
            dtr_n_out <= tx_nclk_in;
         else if (dtr_mode_in == UMF_DTR_485_LO)
            dtr_n_out <= tx_empty_in;
         else if (dtr_mode_in == UMF_DTR_485_HI)
            dtr_n_out <= ~tx_empty_in;
         else if (dtr_mode_in == UMF_DTR_AUTO)
            dtr_n_out <= ~(rx_fill_in >= dtr_thr_in);
         else
            dtr_n_out <= ~mcr_in[UMF_MCR_DTR];
      end
   end

   // start grants: only between characters, flow characters first
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         tx_data_start_out <= 1'b0;
         tx_flow_start_out <= 1'b0;
         tx_held_out <= 1'b0;
      end else begin
         tx_flow_start_out <= tx_flow_req_in & ~tx_busy_in &
            ~tx_flow_start_out & ~tx_data_start_out;
         tx_data_start_out <= tx_data_req_in & ~tx_busy_in & ~hold &
            ~tx_flow_req_in & ~tx_flow_start_out &
            ~tx_data_start_out;
         tx_held_out <= hold;
      end
   end

   // edge pulses of the selected clocks; inputs already synchronous
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         tx_src_q <= 1'b0;
         rx_src_q <= 1'b0;
         tx_tick_out <= 1'b0;
         rx_tick_out <= 1'b0;
      end else begin
         tx_src_q <= tx_src;
         rx_src_q <= rx_src;
         tx_tick_out <= tx_src & ~tx_src_q;
         rx_tick_out <= rx_src & ~rx_src_q;
      end
   end

   // ring status and queue depth
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ring_out <= 1'b0;
         fifo_deep_out <= 1'b0;
      end else begin
         ring_out <= ~ri_n_in & ~cks_in[UMF_CKS_TX_EXT];
         fifo_deep_out <= queue_depth_select_pin_in |
                          flow_in[UMF_FLOW_DEEP];
      end
   end
endmodule // umf_chan
`default_nettype wire

// ==== testbench/umf_modem_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module umf_modem_partner (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic cts_off_in,
   input wire logic dsr_off_in,
   input wire logic ring_in,
   input wire logic go_in,
   input wire logic clk_on_ri_in,
   input wire logic [6:0] periods_in,
   output logic cts_n_out,
   output logic dsr_n_out,
   output logic ri_n_out
);
   logic [7:0] left;
   logic [1:0] hc;
   logic lvl;
   // whole periods only, so a burst never leaves a stray edge behind
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         left <= 8'h00;
         hc <= 2'h0;
         lvl <= 1'b1;
      end else if (go_in) begin
         left <= {periods_in, 1'b0};
         hc <= 2'h0;
      end else if (left != 8'h00) begin
         hc <= hc + 2'h1;
         if (hc == 2'h3) begin
            lvl <= ~lvl;
            left <= left - 8'h01;
         end
      end
   end
   // lines are active low; the clock rests high between bursts
   assign cts_n_out = cts_off_in;
   assign dsr_n_out = (left != 8'h00 && !clk_on_ri_in) ? lvl : dsr_off_in;
   assign ri_n_out = (left != 8'h00 && clk_on_ri_in) ? lvl : ~ring_in;
endmodule // umf_modem_partner
`default_nettype wire

// ==== testbench/tb_uart_modem_flow_pins.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_uart_modem_flow_pins;
   import umf_pkg::*;
   typedef struct packed {
      logic [3:0] flow;
      logic [1:0] additional_control_register;
      logic [1:0] mcr;
      logic [7:0] fill;
      logic txe;
      logic rts_n;
      logic dtr_n;
   } umf_tb_row_s;
   logic clk_sys_in, srst_in, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] rx_fill;
   logic [1:0] tx_empty, tx_busy, data_req, flow_req, tx_bclk, tx_nclk;
   logic [1:0] rx_bclk, data_go, flow_go, tx_tick, rx_tick, deep, rts_n;
   logic [1:0] dtr_n, ring_out, cts_off, dsr_off, ring, go, on_ri;
   wire logic [1:0] cts_n, dsr_n, ri_n;
   logic [6:0] periods;
   logic depth_pin, rerr, counting, prev_dtr;
   int error_cnt, n_checks, evt_cnt, ch, sel;
   bit got;
   // flow, acr mode, mcr, fill, tx empty, expected rts_n, dtr_n
   umf_tb_row_s rows[12] = '{
      '{4'h0, 2'h0, 2'h0, 8'h00, 1'b0, 1'b1, 1'b1},
      '{4'h0, 2'h0, 2'h3, 8'h00, 1'b0, 1'b0, 1'b0},
      '{4'h0, 2'h0, 2'h1, 8'h00, 1'b0, 1'b1, 1'b0},
      '{4'h1, 2'h0, 2'h0, 8'h0F, 1'b0, 1'b0, 1'b1},
      '{4'h1, 2'h0, 2'h1, 8'h10, 1'b0, 1'b1, 1'b0},
      '{4'h1, 2'h0, 2'h3, 8'hFF, 1'b0, 1'b1, 1'b0},
      '{4'h0, 2'h1, 2'h0, 8'h1F, 1'b0, 1'b1, 1'b1},
      '{4'h0, 2'h1, 2'h2, 8'h20, 1'b0, 1'b0, 1'b0},
      '{4'h0, 2'h2, 2'h0, 8'h00, 1'b1, 1'b1, 1'b1},
      '{4'h0, 2'h2, 2'h0, 8'h00, 1'b0, 1'b1, 1'b0},
      '{4'h0, 2'h3, 2'h0, 8'h00, 1'b1, 1'b1, 1'b0},
      '{4'h0, 2'h3, 2'h0, 8'h00, 1'b0, 1'b1, 1'b1}};

   umf_modem_pins #(.NCH(2), .FW(8)) umf_modem_pins_inst (
      .clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .rx_fill_in(rx_fill), .tx_empty_in(tx_empty),
      .tx_busy_in(tx_busy), .tx_data_req_in(data_req),
      .tx_flow_req_in(flow_req), .tx_bclk_in(tx_bclk), .tx_nclk_in(tx_nclk),
      .rx_bclk_in(rx_bclk), .tx_data_start_out(data_go),
      .tx_flow_start_out(flow_go), .tx_tick_out(tx_tick),
      .rx_tick_out(rx_tick), .fifo_deep_out(deep), .cts_n_in(cts_n),
      .dsr_n_in(dsr_n), .ri_n_in(ri_n),
      .queue_depth_select_pin_in(depth_pin), .rts_n_out(rts_n),
      .dtr_n_out(dtr_n), .ring_out(ring_out));
   for (genvar g = 0; g < 2; g++) begin : g_modem
      umf_modem_partner umf_modem_partner_inst (
         .clk_in(clk_sys_in), .srst_in(srst_in), .cts_off_in(cts_off[g]),
         .dsr_off_in(dsr_off[g]), .ring_in(ring[g]), .go_in(go[g]),
         .clk_on_ri_in(on_ri[g]), .periods_in(periods),
         .cts_n_out(cts_n[g]), .dsr_n_out(dsr_n[g]), .ri_n_out(ri_n[g]));
   end

   // 250 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // count route events; dtr counts rising edges so polarity does not matter
   always @(posedge clk_sys_in) begin
      prev_dtr <= dtr_n[ch];
      if (!counting) evt_cnt <= 0;
      else if (sel == 0 ? rx_tick[ch] : sel == 1 ? tx_tick[ch] :
               dtr_n[ch] && !prev_dtr) evt_cnt <= evt_cnt + 1;
   end
   // hang guard
   initial begin
      repeat (50000) @(posedge clk_sys_in);
      error_cnt++;
      end_of_test();
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer to channel ch; holds everything until pready
   task automatic apb(input logic wr, input logic [4:0] off,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {7'(ch), off};
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         error_cnt++;
         end_of_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // watch ten cycles for a start grant
   task automatic wait_go(input logic fl, output bit hit);
      hit = 0;
      repeat (10) begin
         @(posedge clk_sys_in);
         if ((fl ? flow_go[ch] : data_go[ch]) === 1'b1) hit = 1;
      end
   endtask

   initial begin
      srst_in = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, rx_fill, tx_empty} = '0;
      {tx_busy, data_req, flow_req, tx_bclk, tx_nclk, rx_bclk} = '0;
      {cts_off, dsr_off, ring, go, on_ri, periods, depth_pin} = '0;
      {ch, sel, counting, error_cnt, n_checks} = '0;
      tick(5);
      srst_in <= 1'b0;
      tick(1);
      `CHK("pins after reset", 4'hF, {rts_n, dtr_n})
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 5'(i * 4), 32'h0);
         `CHK("reg reset", i == 4 ? {16'h0, UMF_THR_RST, UMF_THR_RST} : 0, rdat)
      end
      apb(1'b1, UMF_OFF_ACR, 32'h18);
      apb(1'b0, UMF_OFF_ACR, 32'h0);
      `CHK("acr back", 32'h18, rdat)
      apb(1'b1, UMF_OFF_STAT, 32'hFF);
      `CHK("status wr err", 1'b0, rerr)
      apb(1'b0, 5'h18, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
      `CHK("unmapped data", 32'h0, rdat)
      ch = 2;
      apb(1'b0, UMF_OFF_MCR, 32'h0);
      `CHK("bad channel", 1'b1, rerr)
      for (ch = 0; ch < 2; ch++) begin
         apb(1'b1, UMF_OFF_THR, 32'h2010);
         foreach (rows[i]) begin
            rx_fill[ch*8 +: 8] <= rows[i].fill;
            tx_empty[ch] <= rows[i].txe;
            apb(1'b1, UMF_OFF_FLOW, 32'(rows[i].flow));
            apb(1'b1, UMF_OFF_ACR, 32'(rows[i].additional_control_register) << UMF_ACR_DTR_LO);
            apb(1'b1, UMF_OFF_MCR, 32'(rows[i].mcr));
            tick(3);
            `CHK("rts_n", rows[i].rts_n, rts_n[ch])
            `CHK("dtr_n", rows[i].dtr_n, dtr_n[ch])
         end
      end
      for (ch = 0; ch < 2; ch++) begin
         apb(1'b1, UMF_OFF_ACR, 32'h0);
         // held by cts, held by dsr, then auto off with cts still high
         for (int c = 0; c < 3; c++) begin
            apb(1'b1, UMF_OFF_FLOW, c == 0 ? 32'h2 : c == 1 ? 32'h4 : 32'h0);
            cts_off[ch] <= c != 1;
            dsr_off[ch] <= c == 1;
            data_req[ch] <= 1'b1;
            wait_go(1'b0, got);
            `CHK("data grant", c == 2, got)
            flow_req[ch] <= 1'b1;
            wait_go(1'b1, got);
            flow_req[ch] <= 1'b0;
            `CHK("flow grant", 1'b1, got)
            cts_off[ch] <= 1'b0;
            dsr_off[ch] <= 1'b0;
            wait_go(1'b0, got);
            data_req[ch] <= 1'b0;
            `CHK("resume", 1'b1, got)
         end
         apb(1'b1, UMF_OFF_FLOW, 32'h0);
         // dsr as rx clock, ri as tx clock, 1x and nx out on dtr
         for (sel = 0; sel < 4; sel++) begin
            apb(1'b1, UMF_OFF_CKS, sel == 0 ? 32'h01 : sel == 1 ? 32'h40 :
                sel == 2 ? 32'h10 : 32'h20);
            dsr_off[ch] <= 1'b1;
            on_ri[ch] <= sel == 1;
            tick(4);
            counting <= 1'b1;
            if (sel < 2) begin
               periods <= 7'd5;
               go[ch] <= 1'b1;
               tick(1);
               go[ch] <= 1'b0;
               tick(44);
            end else begin
               repeat (10) begin
                  tick(4);
                  if (sel == 2) tx_bclk[ch] <= ~tx_bclk[ch];
                  else tx_nclk[ch] <= ~tx_nclk[ch];
               end
            end
            tick(6);
            `CHK("clock edges", 5, evt_cnt)
            counting <= 1'b0;
            apb(1'b1, UMF_OFF_CKS, 32'h0);
         end
         for (int i = 0; i < 2; i++) begin
            ring[ch] <= i[0];
            tick(3);
            `CHK("ring", i[0], ring_out[ch])
         end
         ring[ch] <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            depth_pin <= i == 1;
            apb(1'b1, UMF_OFF_FLOW, i == 2 ? 32'h8 : 32'h0);
            tick(3);
            `CHK("deep", i != 0, deep[ch])
         end
         depth_pin <= 1'b0;
      end
      end_of_test();
   end
endmodule // tb_uart_modem_flow_pins
`default_nettype wire
